/* hdl/asttm_top.sv */
// sticky status, masks, alert pin, pin function select and throttle timer
`timescale 1ns/10ps
`default_nettype none
`include "asttm_regs.svh"

// Functional notes
// - primary status top bit shows any secondary status bit is set
// - primary bits 6..1 flag temperature and supply window violations
// - primary bit 0 flags 2.5 V, or throttle line when so configured
// - secondary bits 7 and 6 flag remote diode 2 and 1 faults
// - secondary bit 5 flags fan 4 slow, timer limit, or gpio state
// - secondary bits 4..2 flag fans 3, 2, 1 below minimum speed
// - secondary bit 1 flags a critical throttle temperature overrun
// - secondary bit 0 flags 12 V violation or voltage id change
// - status bit stays set until condition gone and register read
// - alert stays low while out of limit and until status read
// - mask blocks only the alert, status still sets
// - primary mask mirrors primary status; top bit masks all secondary
// - secondary mask mirrors secondary status bit for bit
// - alert off after reset; config bit picks alert or fan drive 2
// - two-bit field picks tach, throttle, alert or gpio role
// - throttle enable makes dedicated pin throttle, else 2.5 V input
// - override runs fans full while throttle low, if already running
// - timer sums throttle-asserted time, clears on read, saturates
// - bit 0 sets on first assertion, then counts 22.76 ms units
// - read during assertion restarts timer with bit 0 set
// - timer above limit sets secondary bit 5 in throttle role; zero limit on first
module asttm_top
  import asttm_pkg::*;
#(
  parameter int TMR_TICK_CYCLES = `ASTTM_TMR_LSB_NS / `ASTTM_CLK_NS
) (
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire asttm_reg_req_t reg_req_i,
  output logic [7:0]          reg_rdata_o,
  output logic                reg_rvalid_o,
  input  wire asttm_cond_t    cond_i,
  input  wire logic [5:0]     voltage_id_code_i,
  input  wire logic           vid_change_sel_i,
  input  wire logic           fans_running_i,
  input  wire logic           fan_drive_2_i,
  input  wire logic           thermal_throttle_line_line_n_i,
  input  wire logic           mf_pin_i,
  output logic                mf_pin_o,
  output logic                mf_pin_oe_o,
  output logic                pin10_o,
  output logic                pin10_oe_o,
  output logic                fan_full_speed_o
);

  logic [7:0]           stat1_ff;
  logic [7:0]           stat2_ff;
  logic [7:0]           mask1_ff;
  logic [7:0]           mask2_ff;
  logic [7:0]           cfg3_ff;
  logic [7:0]           cfg4_ff;
  logic [7:0]           tmr_lim_ff;
  logic [7:0]           units_ff;
  logic                 seen_ff;
  logic [`ASTTM_TICK_W-1:0] tick_ff;
  logic [5:0]           vid_prev_ff;
  logic                 vid_valid_ff;
  logic                 alert_act_ff;
  logic [7:0]           stat1_src;
  logic [7:0]           stat2_src;
  logic [7:0]           tmr_value;
  logic                 thermal_throttle_line_en;
  logic                 ded_act;
  logic                 mf_act;
  logic                 thr_act;
  logic                 thr_exceed;
  logic                 vid_change;
  logic                 mf_bit;
  logic                 alert_any;
  logic                 rd_stat1;
  logic                 rd_stat2;
  logic                 rd_tmr;
  logic                 tick_done;
  asttm_mf_mode_t       mf_mode;

  // register port decode
  assign rd_stat1 = reg_req_i.rd && (reg_req_i.addr == `ASTTM_OFS_STAT1);
  assign rd_stat2 = reg_req_i.rd && (reg_req_i.addr == `ASTTM_OFS_STAT2);
  assign rd_tmr   = reg_req_i.rd && (reg_req_i.addr == `ASTTM_OFS_TMR);

  // pin roles: the multi-function pin only throttles with enable set
  assign mf_mode  = asttm_mf_mode_t'(
                    cfg4_ff[`ASTTM_CFG4_MF_MSB:`ASTTM_CFG4_MF_LSB]);
  assign thermal_throttle_line_en = cfg3_ff[`ASTTM_CFG3_THR_BIT];
  assign ded_act  = thermal_throttle_line_en && !thermal_throttle_line_line_n_i;
  assign mf_act   = thermal_throttle_line_en && (mf_mode == ASTTM_MF_THR)
                    && !mf_pin_i;
  assign thr_act  = ded_act || mf_act;

  // a zero limit trips on the first assertion, else on exceeding it
  assign thr_exceed = (tmr_lim_ff == `ASTTM_RST_TMR_LIM) ? seen_ff
                      : (units_ff > tmr_lim_ff);

  // voltage id change, suppressed until one sample has been taken
  assign vid_change = vid_valid_ff && (vid_prev_ff != voltage_id_code_i);

  // shared bit 5 follows the multi-function pin role
  always_comb begin
    unique case (mf_mode)
      ASTTM_MF_TACH:  mf_bit = cond_i.fan4_slow;
      ASTTM_MF_THR:   mf_bit = thermal_throttle_line_en && thr_exceed;
      ASTTM_MF_ALERT: mf_bit = 1'b0;
      ASTTM_MF_GPIO:  mf_bit = mf_pin_i;
    endcase
  end

  // raw set sources, laid out as the status registers
  assign stat1_src = {1'b0,
                      cond_i.remote2_temp,
                      cond_i.local_temp,
                      cond_i.remote1_temp,
                      cond_i.five_volt,
                      cond_i.main_supply,
                      cond_i.cpu_core_supply,
                      thermal_throttle_line_en ? ded_act : cond_i.two_five_volt};
  assign stat2_src = {cond_i.diode2_fault,
                      cond_i.diode1_fault,
                      mf_bit,
                      cond_i.fan_three_slow_flag_slow,
                      cond_i.fan_two_slow_flag_slow,
                      cond_i.fan_one_slow_flag_slow,
                      cond_i.overtemp,
                      vid_change_sel_i ? vid_change
                                       : cond_i.twelve_volt};

  // sticky status: a read clears only bits whose cause is gone, set wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat1_ff <= `ASTTM_RST_BYTE;
      stat2_ff <= `ASTTM_RST_BYTE;
    end else begin
      stat1_ff <= (rd_stat1 ? `ASTTM_RST_BYTE : stat1_ff) | stat1_src;
      stat2_ff <= (rd_stat2 ? `ASTTM_RST_BYTE : stat2_ff) | stat2_src;
    end
  end

  // writable configuration, masks and timer limit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask1_ff   <= `ASTTM_RST_MASK;
      mask2_ff   <= `ASTTM_RST_MASK;
      cfg3_ff    <= `ASTTM_RST_CFG;
      cfg4_ff    <= `ASTTM_RST_CFG;
      tmr_lim_ff <= `ASTTM_RST_TMR_LIM;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `ASTTM_OFS_MASK1:   mask1_ff   <= reg_req_i.wdata;
        `ASTTM_OFS_MASK2:   mask2_ff   <= reg_req_i.wdata;
        `ASTTM_OFS_CFG3:    cfg3_ff    <= reg_req_i.wdata;
        `ASTTM_OFS_CFG4:    cfg4_ff    <= reg_req_i.wdata;
        `ASTTM_OFS_TMR_LIM: tmr_lim_ff <= reg_req_i.wdata;
        default:            ;
      endcase
    end
  end

  // timer value: bit 0 alone until the first unit has passed
  assign tmr_value = (units_ff == `ASTTM_RST_BYTE)
                     ? {7'h00, seen_ff} : units_ff;

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= `ASTTM_RST_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.addr)
          `ASTTM_OFS_STAT1:   reg_rdata_o <= {|stat2_ff,
                                              stat1_ff[6:0]};
          `ASTTM_OFS_STAT2:   reg_rdata_o <= stat2_ff;
          `ASTTM_OFS_MASK1:   reg_rdata_o <= mask1_ff;
          `ASTTM_OFS_MASK2:   reg_rdata_o <= mask2_ff;
          `ASTTM_OFS_CFG3:    reg_rdata_o <= cfg3_ff;
          `ASTTM_OFS_CFG4:    reg_rdata_o <= cfg4_ff;
          `ASTTM_OFS_TMR:     reg_rdata_o <= tmr_value;
          `ASTTM_OFS_TMR_LIM: reg_rdata_o <= tmr_lim_ff;
          default:            reg_rdata_o <= `ASTTM_RST_BYTE;
        endcase
      end
    end
  end

  // tick divider runs only while asserted, so partial periods accumulate
  assign tick_done = (tick_ff == `ASTTM_TICK_W'(TMR_TICK_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_ff <= `ASTTM_TICK_ZERO;
    end else if (rd_tmr || tick_done) begin
      tick_ff <= `ASTTM_TICK_ZERO;
    end else if (thr_act) begin
      tick_ff <= tick_ff + `ASTTM_TICK_W'(1);
    end
  end

  // unit count saturates at full scale; a read restarts from zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      units_ff <= `ASTTM_RST_BYTE;
      seen_ff  <= 1'b0;
    end else if (rd_tmr) begin
      units_ff <= `ASTTM_RST_BYTE;
      seen_ff  <= thr_act;
    end else begin
      if (thr_act) begin
        seen_ff <= 1'b1;
      end
      if (thr_act && tick_done && (units_ff != `ASTTM_TMR_FULL)) begin
        units_ff <= units_ff + `ASTTM_TMR_ONE;
      end
    end
  end

  // last voltage id sample for change detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_prev_ff  <= `ASTTM_RST_VID;
      vid_valid_ff <= 1'b0;
    end else begin
      vid_prev_ff  <= voltage_id_code_i;
      vid_valid_ff <= 1'b1;
    end
  end

  // unmasked status drives the alert; summary mask covers all secondary
  assign alert_any = (|(stat1_ff[6:0] & ~mask1_ff[6:0]))
                     || ((|(stat2_ff & ~mask2_ff))
                         && !mask1_ff[`ASTTM_MASK1_SUM_BIT]);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alert_act_ff <= 1'b0;
    end else begin
      alert_act_ff <= alert_any;
    end
  end

  // pin drive: alert pins are open drain, fan drive 2 is push-pull
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin10_o     <= 1'b0;
      pin10_oe_o  <= 1'b0;
      mf_pin_o    <= `ASTTM_OD_LOW;
      mf_pin_oe_o <= 1'b0;
    end else begin
      if (cfg3_ff[`ASTTM_CFG3_ALERT_BIT]) begin
        pin10_o    <= `ASTTM_OD_LOW;
        pin10_oe_o <= alert_any;
      end else begin
        pin10_o    <= fan_drive_2_i;
        pin10_oe_o <= 1'b1;
      end
      mf_pin_o    <= `ASTTM_OD_LOW;
      mf_pin_oe_o <= (mf_mode == ASTTM_MF_ALERT) && alert_any;
    end
  end

  // full speed only if fans already spin; off when override clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fan_full_speed_o <= 1'b0;
    end else begin
      fan_full_speed_o <= cfg3_ff[`ASTTM_CFG3_FULL_SPEED_OVERRIDE_BIT] && thr_act
                          && fans_running_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_STICKY_HOLD: assert property (
    $fell(stat1_ff[1]) |-> $past(rd_stat1) && !$past(cond_i.cpu_core_supply))
    else $error("primary status bit dropped without a qualifying read");

  AST_COND_SETS: assert property (
    cond_i.remote2_temp |=> stat1_ff[6])
    else $error("remote 2 violation did not set status");

  AST_SUMMARY_BIT: assert property (
    rd_stat1 && (|stat2_ff) |=> reg_rvalid_o && reg_rdata_o[7])
    else $error("summary bit missing while secondary status set");

  AST_MASK_KEEPS_STATUS: assert property (
    cond_i.fan_one_slow_flag_slow && mask2_ff[2] |=> stat2_ff[2])
    else $error("masked source failed to set status");

  AST_ALERT_FOLLOWS: assert property (
    stat1_ff[4] && !mask1_ff[4] && cfg3_ff[0]
    |=> pin10_oe_o && !pin10_o && alert_act_ff)
    else $error("alert not driven for unmasked status");

  AST_SUMMARY_MASK: assert property (
    (stat1_ff[6:0] == 7'h00) && mask1_ff[7] |=> !alert_act_ff)
    else $error("secondary status reached alert through summary mask");

  AST_ALERT_DEFAULT: assert property (
    !cfg3_ff[0] |=> pin10_oe_o && (pin10_o == $past(fan_drive_2_i)))
    else $error("pin 10 not fan drive while alert disabled");

  AST_FULL_SPEED_OVERRIDE_GATED: assert property (
    !fans_running_i || !thr_act |=> !fan_full_speed_o)
    else $error("full speed without running fans and throttle");

  AST_TIMER_REARM: assert property (
    rd_tmr && thr_act |=> seen_ff && (units_ff == 8'h00) && (tick_ff == '0))
    else $error("timer did not restart on read during assertion");

  AST_TIMER_SAT: assert property (
    (units_ff == 8'hff) && !rd_tmr |=> (units_ff == 8'hff))
    else $error("timer left full scale without a read");

  AST_THR_DISABLED: assert property (
    !thermal_throttle_line_en && cond_i.two_five_volt |=> stat1_ff[0])
    else $error("2.5 V violation lost while throttle disabled");

  AST_ZERO_LIMIT: assert property (
    (mf_mode == ASTTM_MF_THR) && thermal_throttle_line_en && (tmr_lim_ff == 8'h00)
    && seen_ff ##1 (mf_mode == ASTTM_MF_THR) |-> stat2_ff[5])
    else $error("zero limit did not flag first assertion");

endmodule
`default_nettype wire

/* hdl/asttm_regs.svh */
// register offsets, field positions, reset values and timing constants
`ifndef ASTTM_REGS_SVH
`define ASTTM_REGS_SVH

// register offsets on the serial-interface register port
`define ASTTM_OFS_STAT1      8'h41
`define ASTTM_OFS_STAT2      8'h42
`define ASTTM_OFS_MASK1      8'h74
`define ASTTM_OFS_MASK2      8'h75
`define ASTTM_OFS_CFG3       8'h78
`define ASTTM_OFS_TMR        8'h79
`define ASTTM_OFS_TMR_LIM    8'h7a
`define ASTTM_OFS_CFG4       8'h7d

// configuration field positions
`define ASTTM_CFG3_ALERT_BIT 0
`define ASTTM_CFG3_THR_BIT   1
`define ASTTM_CFG3_FULL_SPEED_OVERRIDE_BIT 2
`define ASTTM_CFG4_MF_LSB    0
`define ASTTM_CFG4_MF_MSB    1
`define ASTTM_MASK1_SUM_BIT  7

// reset values, timer full scale and count step
`define ASTTM_RST_BYTE       8'h00
`define ASTTM_RST_MASK       8'h00
`define ASTTM_RST_CFG        8'h00
`define ASTTM_RST_TMR_LIM    8'h00
`define ASTTM_RST_VID        6'h00
`define ASTTM_TMR_FULL       8'hff
`define ASTTM_TMR_ONE        8'h01

// throttle timer resolution, clock period and tick counter width
`define ASTTM_TMR_LSB_NS     22760000
`define ASTTM_CLK_NS         8
`define ASTTM_TICK_W         22
`define ASTTM_TICK_ZERO      22'h000000

// open-drain output level while driving
`define ASTTM_OD_LOW         1'b0

`endif

/* hdl/asttm_pkg.sv */
// types shared by the alert, status and throttle timer block
package asttm_pkg;

  // role of the multi-function pin, in register encoding order
  typedef enum logic [1:0] {
    ASTTM_MF_TACH,
    ASTTM_MF_THR,
    ASTTM_MF_ALERT,
    ASTTM_MF_GPIO
  } asttm_mf_mode_t;

  // out-of-limit levels from the comparators and fault detectors
  typedef struct packed {
    logic diode2_fault;
    logic diode1_fault;
    logic fan4_slow;
    logic fan_three_slow_flag_slow;
    logic fan_two_slow_flag_slow;
    logic fan_one_slow_flag_slow;
    logic overtemp;
    logic twelve_volt;
    logic remote2_temp;
    logic local_temp;
    logic remote1_temp;
    logic five_volt;
    logic main_supply;
    logic cpu_core_supply;
    logic two_five_volt;
  } asttm_cond_t;

  // one access on the internal register port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } asttm_reg_req_t;

endpackage

/* verification/asttm_host.sv */
// host model driving single reads and writes on the register port
`timescale 1ns/10ps
`default_nettype none
module asttm_host
  import asttm_pkg::*;
(
  input  wire logic       clk_i,
  output asttm_reg_req_t  req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial req_o = '0;

  // one write, held across exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_i);
    req_o.wr = 1'b0;
  endtask

  // one read; data taken while the valid pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_i);
    req_o.rd = 1'b0;
    n = 0;
    // bounded so a missing valid cannot hang the host
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* verification/alert_status_thermal_throttle_line_timer_tb.sv */
// self-checking bench for status, masks, alert pins and throttle timer
`timescale 1ns/10ps
`default_nettype none
module alert_status_thermal_throttle_line_timer_tb
  import asttm_pkg::*;
;
  localparam int TK = 8;
  logic           clk;
  logic           rst_n;
  asttm_reg_req_t req;
  asttm_cond_t    cond;
  logic [7:0]     rdata;
  logic           rvalid;
  logic [5:0]     voltage_id_code;
  logic           vsel, fans, fd2, thr_n, mf_i;
  logic           mf_o, mf_oe, p10, p10_oe, full;
  int             err_total;
  int             checks;

  asttm_top #(.TMR_TICK_CYCLES(TK)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .cond_i(cond),
    .voltage_id_code_i(voltage_id_code), .vid_change_sel_i(vsel),
    .fans_running_i(fans), .fan_drive_2_i(fd2),
    .thermal_throttle_line_line_n_i(thr_n), .mf_pin_i(mf_i), .mf_pin_o(mf_o),
    .mf_pin_oe_o(mf_oe), .pin10_o(p10), .pin10_oe_o(p10_oe),
    .fan_full_speed_o(full)
  );

  asttm_host u_host (
    .clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic results;
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hang far beyond the expected few thousand cycles counts as failure
  initial begin
    #200000;
    err_total++;
    results;
  end

  initial begin
    logic [7:0] e1;
    logic [7:0] e2;
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    cond = '0;
    voltage_id_code = 6'h00;
    {vsel, fans, fd2, mf_i} = 4'h0;
    thr_n = 1'b1;
    cyc(6);
    rst_n = 1'b1;
    fd2 = 1'b1;
    cyc(2);
    chk({6'h00, p10_oe, p10}, 8'h03);
    // pin 10 must follow the fan drive both ways, not sit at one level
    fd2 = 1'b0;
    cyc(2);
    chk({6'h00, p10_oe, p10}, 8'h02);
    fd2 = 1'b1;
    // reset values, unmapped read, writes to read-clear places ignored
    rchk(8'h74, 8'h00);
    rchk(8'h75, 8'h00);
    rchk(8'h79, 8'h00);
    rchk(8'h10, 8'h00);
    u_host.wr(8'h74, 8'ha5);
    u_host.wr(8'h41, 8'hff);
    rchk(8'h74, 8'ha5);
    rchk(8'h41, 8'h00);
    u_host.wr(8'h74, 8'h00);
    // every source alone, alert routed to pin10
    u_host.wr(8'h78, 8'h01);
    for (int i = 0; i < 15; i++) begin
      cond = asttm_cond_t'(15'h0001 << i);
      cyc(3);
      chk({7'h00, p10_oe}, 8'h01);
      cond = '0;
      e1 = (i < 7) ? 8'(1 << i) : 8'h80;
      e2 = (i < 7) ? 8'h00 : 8'(1 << (i - 7));
      rchk(8'h41, e1);
      rchk(8'h42, e2);
      cyc(2);
      chk({7'h00, p10_oe}, 8'h00);
    end
    // sticky while cause persists, cleared only after it is gone
    cond.fan_one_slow_flag_slow = 1'b1;
    cyc(3);
    rchk(8'h42, 8'h04);
    rchk(8'h42, 8'h04);
    cond = '0;
    rchk(8'h42, 8'h04);
    rchk(8'h42, 8'h00);
    // masks stop the alert only
    u_host.wr(8'h74, 8'h7f);
    u_host.wr(8'h75, 8'hff);
    cond = '1;
    cyc(3);
    chk({7'h00, p10_oe}, 8'h00);
    cond = '0;
    rchk(8'h41, 8'hff);
    rchk(8'h42, 8'hff);
    u_host.wr(8'h74, 8'h80);
    u_host.wr(8'h75, 8'h00);
    cond.fan_one_slow_flag_slow = 1'b1;
    cyc(3);
    chk({7'h00, p10_oe}, 8'h00);
    cond = '0;
    u_host.wr(8'h74, 8'h00);
    cyc(2);
    chk({7'h00, p10_oe}, 8'h01);
    rchk(8'h42, 8'h04);
    cyc(2);
    chk({7'h00, p10_oe}, 8'h00);
    // multi-function pin as alert, then as general-purpose input
    u_host.wr(8'h7d, 8'h02);
    cond.fan_one_slow_flag_slow = 1'b1;
    cyc(3);
    chk({6'h00, mf_oe, mf_o}, 8'h02);
    cond = '0;
    rchk(8'h42, 8'h04);
    cyc(2);
    chk({7'h00, mf_oe}, 8'h00);
    u_host.wr(8'h7d, 8'h03);
    mf_i = 1'b1;
    cyc(3);
    mf_i = 1'b0;
    rchk(8'h42, 8'h20);
    // voltage id change replaces the 12 V source
    vsel = 1'b1;
    voltage_id_code = 6'h15;
    cyc(3);
    rchk(8'h42, 8'h01);
    rchk(8'h42, 8'h00);
    vsel = 1'b0;
    // dedicated throttle line, override and accumulation
    u_host.wr(8'h7d, 8'h00);
    u_host.wr(8'h78, 8'h06);
    fans = 1'b1;
    thr_n = 1'b0;
    cyc(2);
    chk({7'h00, full}, 8'h01);
    cyc(8);
    thr_n = 1'b1;
    cyc(4);
    chk({7'h00, full}, 8'h00);
    thr_n = 1'b0;
    cyc(10);
    thr_n = 1'b1;
    rchk(8'h41, 8'h01);
    rchk(8'h79, 8'h02);
    rchk(8'h79, 8'h00);
    fans = 1'b0;
    thr_n = 1'b0;
    cyc(2);
    chk({7'h00, full}, 8'h00);
    rchk(8'h79, 8'h01);
    rchk(8'h79, 8'h01);
    thr_n = 1'b1;
    rchk(8'h79, 8'h01);
    rchk(8'h79, 8'h00);
    // throttle on the multi-function pin against the limit
    u_host.wr(8'h7d, 8'h01);
    mf_i = 1'b0;
    cyc(3);
    mf_i = 1'b1;
    rchk(8'h42, 8'h20);
    rchk(8'h79, 8'h01);
    rchk(8'h42, 8'h20);
    rchk(8'h42, 8'h00);
    u_host.wr(8'h7a, 8'h01);
    mf_i = 1'b0;
    cyc(12);
    mf_i = 1'b1;
    rchk(8'h42, 8'h00);
    mf_i = 1'b0;
    cyc(10);
    mf_i = 1'b1;
    rchk(8'h42, 8'h20);
    rchk(8'h79, 8'h02);
    rchk(8'h42, 8'h20);
    rchk(8'h42, 8'h00);
    // saturation at full scale
    thr_n = 1'b0;
    cyc(2100);
    thr_n = 1'b1;
    rchk(8'h79, 8'hff);
    // limit was exceeded while saturating, so the summary bit shows too
    rchk(8'h41, 8'h81);
    rchk(8'h42, 8'h20);
    // throttle disabled: dedicated pin is a plain 2.5 V input
    u_host.wr(8'h78, 8'h00);
    thr_n = 1'b0;
    cyc(4);
    thr_n = 1'b1;
    rchk(8'h41, 8'h00);
    rchk(8'h79, 8'h00);
    results;
  end
endmodule
`default_nettype wire
